// ===== hdl/fmf_ctrl.sv
// Finisher delivery mode check and motor fault supervision
//
// Decided for this implementation: the plain strobed port and the placing of the registers.
`timescale 1ns/1ps
`include "fmf_cfg.svh"

module fmf_ctrl #(
   parameter logic [23:0] T_HOME = 24'(`FMF_MS2CYC(`FMF_T_HOME_MS)),
   parameter logic [23:0] T_STUCK = 24'(`FMF_MS2CYC(`FMF_T_STUCK_MS)),
   parameter logic [23:0] T_AGAIN = 24'(`FMF_MS2CYC(`FMF_T_AGAIN_MS)),
   parameter logic [23:0] T_PULSE = 24'(`FMF_MS2CYC(`FMF_T_PULSE_MS)),
   parameter logic [23:0] T_SIDE = 24'(`FMF_MS2CYC(`FMF_T_SIDE_MS)),
   parameter logic [7:0] PULSE_REQ = `FMF_PULSE_REQ
) (
   input wire logic mclk, // System clock
   input wire logic reset_n, // Synchronous reset
   input wire logic [7:0] addr, // Register byte address
   input wire logic [31:0] wdata, // Write data
   input wire logic wr, // Write strobe
   input wire logic rd, // Read strobe
   output logic [31:0] rdata, // Read data, cycle after rd
   output logic irq, // Unmasked status pending
   input wire logic deliv_req, // Delivery request pulse
   input wire fmf_pkg::fmf_mode_t deliv_mode, // Requested mode
   output logic deliv_accept, // Mode accepted pulse
   output logic deliv_refuse, // Mode refused pulse
   output logic feed_switchback, // Route of last accepted
   input wire logic attachment_sensor, // Unit joined to printer
   output logic attached, // Attachment to printer
   input wire logic punch_drive_on, // Punch drive motor running
   input wire logic punch_home_sensor, // Punch at home
   input wire logic punch_pulse_sensor, // Punch clock pulses
   input wire logic side_to_home, // Slide driven toward home
   input wire logic side_from_home, // Slide driven away
   input wire logic slide_home_sensor, // Slide at home
   input wire fmf_pkg::fmf_jam_t jam_motor_fail, // Feed motor failures
   output logic motor_fail, // Latched motor failure
   output logic jam // Latched jam
);
   import fmf_pkg::*;

   fmf_state_t q, d;
   logic fitted, drive, p_fail, s_fail, s_cond, p_edge;
   logic [4:0] set_v, clr_v;

   // Allowed combination for a route and unit variant
   function automatic logic mode_ok(input logic has_punch,
                                    input fmf_mode_t m);
      logic ok;
      ok = 1'b0;
      if (!m.switchback) begin
         ok = !m.staple && !m.punch && !m.offset;
      end else if (m.staple && m.offset) begin
         ok = 1'b0;
      end else begin
         ok = has_punch || !m.punch;
      end
      return ok;
   endfunction

   assign fitted = q.ctrl[0];
   // Only the punch and side slide motors are supervised; roller motors never are
   assign drive = punch_drive_on && fitted;
   assign p_edge = punch_pulse_sensor && !q.pls_prev;
   assign s_cond = fitted && ((side_to_home && !slide_home_sensor) ||
      (side_from_home && slide_home_sensor));

   always_comb begin
      d = q;
      p_fail = 1'b0;
      d.pls_prev = punch_pulse_sensor;
      d.attached = attachment_sensor;
      d.acc = 1'b0;
      d.refuse = 1'b0;
      d.rdata = 32'h00000000;
      if (deliv_req) begin
         if (q.attached && mode_ok(fitted, deliv_mode)) begin
            d.acc = 1'b1;
            d.sb = deliv_mode.switchback;
         end else begin
            d.refuse = 1'b1;
         end
      end
      // Pulse window runs beside the home tracker, only while driven
      if (q.pls_on && drive) begin
         if (p_edge && q.pcnt + 8'h01 >= PULSE_REQ) begin
            d.pls_on = 1'b0;
         end else if (q.ptmr2 == T_PULSE - 24'h000001) begin
            p_fail = 1'b1;
         end else begin
            d.ptmr2 = q.ptmr2 + 24'h000001;
         end
         if (p_edge) begin
            d.pcnt = q.pcnt + 8'h01;
         end
      end
      case (q.pst)
         FMF_P_IDLE: begin
            d.pls_on = 1'b0;
            if (drive) begin
               d.pst = FMF_P_WAIT_HOME;
               d.ptmr = `FMF_ZERO24;
            end
         end
         FMF_P_WAIT_HOME: begin
            if (!drive) begin
               d.pst = FMF_P_IDLE;
            end else if (punch_home_sensor) begin
               d.pst = FMF_P_AT_HOME;
            end else if (q.ptmr == T_HOME - 24'h000001) begin
               p_fail = 1'b1;
            end else begin
               d.ptmr = q.ptmr + 24'h000001;
            end
         end
         FMF_P_AT_HOME: begin
            if (!drive) begin
               d.pst = FMF_P_IDLE;
            end else if (!punch_home_sensor) begin
               d.pst = FMF_P_AWAY;
               d.ptmr = `FMF_ZERO24;
            end else if (q.stuck == T_STUCK - 24'h000001) begin
               p_fail = 1'b1;
            end else begin
               d.stuck = q.stuck + 24'h000001;
            end
         end
         FMF_P_AWAY: begin
            if (!drive) begin
               d.pst = FMF_P_IDLE;
            end else if (punch_home_sensor) begin
               d.pst = FMF_P_AT_HOME;
            end else if (q.ptmr == T_AGAIN - 24'h000001) begin
               p_fail = 1'b1;
            end else begin
               d.ptmr = q.ptmr + 24'h000001;
            end
         end
         default: begin
            // Wait for the drive to drop so one fault is raised per run
            d.pls_on = 1'b0;
            if (!drive) begin
               d.pst = FMF_P_IDLE;
            end
         end
      endcase
      // Each new home detection restarts stuck and pulse windows
      if (drive && punch_home_sensor && !p_fail &&
          (q.pst == FMF_P_WAIT_HOME || q.pst == FMF_P_AWAY)) begin
         d.stuck = `FMF_ZERO24;
         d.pls_on = 1'b1;
         d.ptmr2 = `FMF_ZERO24;
         d.pcnt = 8'h00;
      end
      if (p_fail) begin
         d.pst = FMF_P_HALT;
         d.pls_on = 1'b0;
      end
      // A stopped motor must not trip the pulse window afterwards
      if (!drive) begin
         d.pls_on = 1'b0;
      end
      // Side registration timer holds at its end while the fault stands
      s_fail = 1'b0;
      if (!s_cond) begin
         d.stmr = `FMF_ZERO24;
      end else if (q.stmr == T_SIDE - 24'h000001) begin
         s_fail = 1'b1;
      end else begin
         d.stmr = q.stmr + 24'h000001;
      end
      set_v = 5'h00;
      set_v[`FMF_B_ATTACH] = q.attached != attachment_sensor;
      set_v[`FMF_B_PUNCH] = p_fail;
      set_v[`FMF_B_SIDE] = s_fail;
      set_v[`FMF_B_JAM] = |jam_motor_fail;
      set_v[`FMF_B_REFUSE] = d.refuse;
      clr_v = 5'h00;
      if (wr) begin
         if (addr == `FMF_A_CTRL) begin
            d.ctrl = wdata[1:0];
         end else if (addr == `FMF_A_STAT) begin
            clr_v = wdata[4:0];
         end else if (addr == `FMF_A_MASK) begin
            d.mask = wdata[4:0];
         end
      end
      // Set beats a same-cycle clear so no event is lost
      d.stat = (q.stat & ~clr_v) | set_v;
      if (rd) begin
         if (addr == `FMF_A_CTRL) begin
            d.rdata = {30'h00000000, q.ctrl};
         end else if (addr == `FMF_A_LIVE) begin
            d.rdata = {26'h0000000, q.pst, jam, motor_fail, q.attached};
         end else if (addr == `FMF_A_STAT) begin
            d.rdata = {27'h0000000, q.stat};
         end else if (addr == `FMF_A_MASK) begin
            d.rdata = {27'h0000000, q.mask};
         end
      end
   end

   always_ff @(posedge mclk) begin
      if (!reset_n) begin
         q <= '0;
         q.pst <= FMF_P_IDLE;
         q.ctrl <= `FMF_CTRL_RST;
         q.mask <= `FMF_MASK_RST;
      end else begin
         q <= d;
      end
   end

   assign rdata = q.rdata;
   assign irq = |(q.stat & q.mask);
   assign attached = q.attached;
   assign deliv_accept = q.acc;
   assign deliv_refuse = q.refuse;
   assign feed_switchback = q.sb;
   assign motor_fail = q.stat[`FMF_B_PUNCH] | q.stat[`FMF_B_SIDE];
   assign jam = q.stat[`FMF_B_JAM];

   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!reset_n);

   sequence s_req_bad;
      deliv_req && deliv_mode.switchback && deliv_mode.staple &&
      deliv_mode.offset;
   endsequence
   sequence s_req_straight_dirty;
      deliv_req && !deliv_mode.switchback &&
      (deliv_mode.staple || deliv_mode.offset || deliv_mode.punch);
   endsequence
   sequence s_home_seen;
      drive && punch_home_sensor &&
      (q.pst == FMF_P_WAIT_HOME || q.pst == FMF_P_AWAY);
   endsequence
   sequence s_home_left;
      drive && !punch_home_sensor && q.pst == FMF_P_AT_HOME;
   endsequence
   sequence s_window_open;
      q.pst == FMF_P_AT_HOME && q.pls_on && q.stuck == `FMF_ZERO24 &&
      q.ptmr2 == `FMF_ZERO24 && q.pcnt == 8'h00;
   endsequence
   sequence s_fault_halt;
      q.pst == FMF_P_HALT && motor_fail;
   endsequence

   AST_ATTACH_FOLLOW: assert property (
      ##1 attached == $past(attachment_sensor))
      else $error("attached does not follow sensor");
   AST_SB_COMBO: assert property (s_req_bad |=> deliv_refuse)
      else $error("staple with offset accepted");
   AST_STRAIGHT: assert property (
      s_req_straight_dirty |=> deliv_refuse && !deliv_accept)
      else $error("straight mode with options accepted");
   AST_NO_PUNCH_UNIT: assert property (
      !fitted |=> !$rose(q.stat[`FMF_B_PUNCH]) &&
      !$rose(q.stat[`FMF_B_SIDE]))
      else $error("fault raised on unit without punch");
   AST_FAIL_LATCH: assert property (
      p_fail |=> q.stat[`FMF_B_PUNCH] && motor_fail)
      else $error("punch fault not latched");
   AST_HOME_TIMEOUT: assert property (
      q.pst == FMF_P_WAIT_HOME && drive && !punch_home_sensor &&
      q.ptmr == T_HOME - 24'h000001 |=> q.pst == FMF_P_HALT)
      else $error("missing home not flagged");
   AST_STUCK: assert property (
      q.pst == FMF_P_AT_HOME && q.stuck == `FMF_ZERO24 && drive &&
      punch_home_sensor |=> q.stuck == 24'h000001 || q.pst != FMF_P_AT_HOME)
      else $error("stuck timer not running");
   AST_SIDE: assert property (
      s_cond && q.stmr == T_SIDE - 24'h000001 |=> q.stat[`FMF_B_SIDE])
      else $error("side fault not latched");
   AST_JAM: assert property (
      |jam_motor_fail |=> jam && (!$rose(motor_fail) || $past(p_fail) ||
      $past(s_fail)))
      else $error("feed motor failure not a jam");
   AST_ONE_ANSWER: assert property (
      deliv_req |=> deliv_accept != deliv_refuse)
      else $error("request not answered exactly once");
   AST_NO_STRAY: assert property (
      !deliv_req |=> !deliv_accept && !deliv_refuse)
      else $error("answer without request");
   AST_DETACHED: assert property (
      deliv_req && !attached |=> deliv_refuse)
      else $error("request accepted while detached");
   AST_PUNCH_UNFIT: assert property (
      deliv_req && deliv_mode.punch && !fitted |=> deliv_refuse)
      else $error("punch accepted on unit without punch");
   AST_PLAIN_OK: assert property (
      deliv_req && attached && deliv_mode == 4'h0 |=>
      deliv_accept && !feed_switchback)
      else $error("plain straight delivery refused");
   AST_SB_OK: assert property (
      deliv_req && attached && deliv_mode.switchback &&
      !(deliv_mode.staple && deliv_mode.offset) &&
      (fitted || !deliv_mode.punch) |=> deliv_accept && feed_switchback)
      else $error("allowed switchback delivery refused");
   AST_REFUSE_FLAG: assert property (
      deliv_refuse |-> q.stat[`FMF_B_REFUSE])
      else $error("refusal not flagged");
   AST_ROLLER_QUIET: assert property (
      |jam_motor_fail && !p_fail && !s_fail |=> !$rose(motor_fail))
      else $error("roller failure raised motor fault");
   AST_HOME_SEEN: assert property (
      s_home_seen ##0 !p_fail |=> s_window_open)
      else $error("home detection did not restart windows");
   AST_HOME_LEFT: assert property (
      s_home_left ##0 !p_fail |=> q.pst == FMF_P_AWAY &&
      q.ptmr == `FMF_ZERO24)
      else $error("leaving home did not start return timer");
   AST_STUCK_END: assert property (
      q.pst == FMF_P_AT_HOME && drive && punch_home_sensor &&
      q.stuck == T_STUCK - 24'h000001 |=> s_fault_halt)
      else $error("held home not flagged");
   AST_AGAIN_END: assert property (
      q.pst == FMF_P_AWAY && drive && !punch_home_sensor &&
      q.ptmr == T_AGAIN - 24'h000001 |=> s_fault_halt)
      else $error("missing return to home not flagged");
   AST_PULSE_END: assert property (
      q.pls_on && drive && !p_edge &&
      q.ptmr2 == T_PULSE - 24'h000001 |=> s_fault_halt)
      else $error("missing clock pulses not flagged");
   AST_PULSE_DONE: assert property (
      q.pls_on && drive && p_edge && !punch_home_sensor &&
      q.pcnt + 8'h01 >= PULSE_REQ |=> !q.pls_on)
      else $error("pulse window did not close");
   AST_HALT_HOLD: assert property (
      q.pst == FMF_P_HALT && drive |=> q.pst == FMF_P_HALT)
      else $error("halted tracker left while driven");
   AST_DRIVE_DROP: assert property (
      !drive |=> q.pst == FMF_P_IDLE && !q.pls_on)
      else $error("tracker active without drive");
   AST_SIDE_CLEAR: assert property (
      !s_cond |=> q.stmr == `FMF_ZERO24)
      else $error("side timer kept running");
   AST_JAM_CLEAR: assert property (
      wr && addr == `FMF_A_STAT && wdata[`FMF_B_JAM] && !(|jam_motor_fail)
      |=> !jam)
      else $error("jam flag not cleared");
endmodule // fmf_ctrl

// ===== inc/fmf_cfg.svh
// Constants of the finisher mode and motor fault block
`ifndef FMF_CFG_SVH
`define FMF_CFG_SVH
`define FMF_CLK_HZ 25000000
`define FMF_CYC_PER_MS (`FMF_CLK_HZ / 1000)
`define FMF_T_HOME_MS 400
`define FMF_T_STUCK_MS 400
`define FMF_T_AGAIN_MS 400
`define FMF_T_PULSE_MS 400
`define FMF_T_SIDE_MS 400
`define FMF_MS2CYC(ms) ((ms) * `FMF_CYC_PER_MS)
`define FMF_PULSE_REQ 8'h04
`define FMF_A_CTRL 8'h00
`define FMF_A_LIVE 8'h04
`define FMF_A_STAT 8'h08
`define FMF_A_MASK 8'h0c
`define FMF_B_ATTACH 0
`define FMF_B_PUNCH 1
`define FMF_B_SIDE 2
`define FMF_B_JAM 3
`define FMF_B_REFUSE 4
`define FMF_CTRL_RST 2'h0
`define FMF_MASK_RST 5'h00
`define FMF_ZERO24 24'h000000
`endif

// ===== inc/fmf_pkg.sv
// Types of the finisher mode and motor fault block
package fmf_pkg;
   typedef enum logic [2:0] {
      FMF_P_IDLE, FMF_P_WAIT_HOME, FMF_P_AT_HOME, FMF_P_AWAY, FMF_P_HALT
   } fmf_pst_t;
   typedef struct packed {
      logic switchback;
      logic staple;
      logic punch;
      logic offset;
   } fmf_mode_t;
   typedef struct packed {
      logic sw_fail;
      logic reg_fail;
      logic feed_fail;
   } fmf_jam_t;
   typedef struct packed {
      fmf_pst_t pst;
      logic [23:0] ptmr;
      logic [23:0] stuck;
      logic [23:0] ptmr2;
      logic [7:0] pcnt;
      logic pls_on;
      logic pls_prev;
      logic [23:0] stmr;
      logic [1:0] ctrl;
      logic [4:0] stat;
      logic [4:0] mask;
      logic attached;
      logic [31:0] rdata;
      logic acc;
      logic refuse;
      logic sb;
   } fmf_state_t;
endpackage : fmf_pkg

// ===== tb/fmf_host_model.sv
// Printer-side model issuing delivery requests
`timescale 1ns/1ps
module fmf_host_model (
   input wire logic mclk, // System clock
   output logic deliv_req, // Delivery request
   output fmf_pkg::fmf_mode_t deliv_mode // Requested mode
);
   import fmf_pkg::*;
   initial begin
      deliv_req = 1'b0;
      deliv_mode = 4'h0;
   end
   // Mode scrambled once released, never left showing
   task automatic send(input fmf_mode_t m);
      @(posedge mclk);
      deliv_req <= 1'b1;
      deliv_mode <= m;
      @(posedge mclk);
      deliv_req <= 1'b0;
      deliv_mode <= ~m;
   endtask
endmodule // fmf_host_model

// ===== tb/fmf_ctrl_tb_top.sv
// Self-checking bench of the finisher mode and motor fault block
`timescale 1ns/1ps
`include "fmf_cfg.svh"
module fmf_ctrl_tb_top;
   import fmf_pkg::*;
   localparam logic [23:0] TS = 24'h000014;
   logic mclk, reset_n, wr, rd, irq, acc, refu, fsb, att_s, attached;
   logic drv, phome, ppls, s_to, s_fr, shome, motor_fail, jam, req;
   logic [7:0] addr;
   logic [31:0] wdata, rdata;
   fmf_mode_t mode;
   fmf_jam_t jf;
   int error_cnt = 0;
   int num_checks = 0;
   logic [31:0] rq[$];
   logic [1:0] dq[$];
   logic [1:0] d;
   logic rd_d = 1'b0, req_d = 1'b0, fit = 1'b0;
   fmf_ctrl #(.T_HOME(TS), .T_STUCK(TS), .T_AGAIN(TS), .T_PULSE(TS),
      .T_SIDE(TS), .PULSE_REQ(8'h03)) dut (.mclk(mclk), .reset_n(reset_n),
      .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
      .irq(irq), .deliv_req(req), .deliv_mode(mode), .deliv_accept(acc),
      .deliv_refuse(refu), .feed_switchback(fsb), .attachment_sensor(att_s),
      .attached(attached), .punch_drive_on(drv), .punch_home_sensor(phome),
      .punch_pulse_sensor(ppls), .side_to_home(s_to), .side_from_home(s_fr),
      .slide_home_sensor(shome), .jam_motor_fail(jf),
      .motor_fail(motor_fail), .jam(jam));
   fmf_host_model host (.mclk(mclk), .deliv_req(req), .deliv_mode(mode));
   initial begin
      mclk = 1'b0;
      forever #20 mclk = ~mclk;
   end
   task automatic chk(string n, logic [31:0] e, logic [31:0] g);
      num_checks++;
      if (g !== e) begin
         error_cnt++;
         $display("mismatch %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic lvl(string n, logic e, ref logic g);
      @(negedge mclk);
      chk(n, {31'h0, e}, {31'h0, g});
      // Back on the rising edge so later stimulus lands there
      @(posedge mclk);
   endtask
   task automatic cyc(int n);
      repeat (n) @(posedge mclk);
   endtask
   always @(posedge mclk) begin
      rd_d <= rd;
      req_d <= req;
   end
   // Results are taken in mid-cycle, once they have settled
   always @(negedge mclk) begin
      if (rd_d) begin
         chk("rdata", rq.pop_front(), rdata);
      end
      if (req_d || acc || refu) begin
         d = dq.pop_front();
         chk("answer", {30'h0, d[1], !d[1]}, {30'h0, acc, refu});
         if (d[1]) begin
            chk("route", {31'h0, d[0]}, {31'h0, fsb});
         end
      end
   end
   task automatic wreg(logic [7:0] a, logic [31:0] v);
      @(posedge mclk);
      addr <= a;
      wdata <= v;
      wr <= 1'b1;
      @(posedge mclk);
      wr <= 1'b0;
   endtask
   task automatic rreg(logic [7:0] a, logic [31:0] e);
      rq.push_back(e);
      @(posedge mclk);
      addr <= a;
      rd <= 1'b1;
      @(posedge mclk);
      rd <= 1'b0;
   endtask
   task automatic dlv(fmf_mode_t m);
      logic e;
      if (!att_s) e = 1'b0;
      else if (!m.switchback) e = {m.staple, m.punch, m.offset} == 3'h0;
      else e = !(m.staple && m.offset) && (!m.punch || fit);
      dq.push_back({e, m.switchback});
      host.send(m);
   endtask
   task automatic clr;
      drv <= 1'b0;
      s_to <= 1'b0;
      s_fr <= 1'b0;
      jf <= 3'h0;
      cyc(2);
      wreg(`FMF_A_STAT, 32'h1f);
      cyc(3);
      lvl("motor_fail", 1'b0, motor_fail);
      lvl("jam", 1'b0, jam);
   endtask
   // Pulses only fit inside the home span
   task automatic ptest(int pre, hold, np, gap, reps, logic e);
      int i;
      drv <= 1'b1;
      cyc(pre);
      repeat (reps) begin
         for (i = 0; i < hold; i++) begin
            phome <= 1'b1;
            ppls <= (i < 2 * np) && i[0];
            @(posedge mclk);
         end
         phome <= 1'b0;
         ppls <= 1'b0;
         cyc(gap);
      end
      cyc(4);
      lvl("motor_fail", e, motor_fail);
      clr;
   endtask
   task automatic stest(logic t, logic f, logic h, int n, logic e);
      s_to <= t;
      s_fr <= f;
      shome <= h;
      cyc(n);
      lvl("motor_fail", e, motor_fail);
      clr;
   endtask
   task automatic print_verdict;
      $display("checks %0d mismatches %0d", num_checks, error_cnt);
      if (error_cnt == 0 && num_checks > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   initial begin
      cyc(20000);
      error_cnt++;
      print_verdict;
   end
   initial begin
      {reset_n, wr, rd, att_s, drv, phome, ppls, s_to, s_fr, shome} = '0;
      addr = 8'h00;
      wdata = 32'h0;
      jf = 3'h0;
      void'($urandom(97083));
      cyc(4);
      reset_n <= 1'b1;
      for (int a = 0; a < 5; a++) begin
         rreg(8'(a * 4), 32'h0);
      end
      wreg(8'h10, 32'hffffffff);
      rreg(8'h10, 32'h0);
      wreg(`FMF_A_MASK, 32'h1f);
      rreg(`FMF_A_MASK, 32'h1f);
      dlv(4'h8);
      att_s <= 1'b1;
      cyc(3);
      lvl("attached", 1'b1, attached);
      lvl("irq", 1'b1, irq);
      rreg(`FMF_A_STAT, 32'h11);
      rreg(`FMF_A_LIVE, 32'h1);
      wreg(`FMF_A_STAT, 32'h1f);
      lvl("irq", 1'b0, irq);
      $display("test registers done");
      for (int f = 0; f < 2; f++) begin
         fit = f[0];
         wreg(`FMF_A_CTRL, 32'(f));
         for (int m = 0; m < 16; m++) begin
            dlv(4'(m));
         end
         repeat (8) dlv(4'($urandom));
      end
      cyc(3);
      lvl("irq", 1'b1, irq);
      clr;
      $display("test modes done");
      ptest(30, 0, 0, 0, 0, 1'b1);
      ptest(5, 8, 3, 5, 4, 1'b0);
      ptest(5, 30, 3, 5, 1, 1'b1);
      ptest(5, 8, 3, 30, 1, 1'b1);
      ptest(5, 8, 2, 15, 1, 1'b1);
      stest(1'b1, 1'b0, 1'b0, 30, 1'b1);
      stest(1'b1, 1'b0, 1'b0, 15, 1'b0);
      stest(1'b0, 1'b1, 1'b1, 30, 1'b1);
      stest(1'b0, 1'b1, 1'b0, 30, 1'b0);
      wreg(`FMF_A_CTRL, 32'h0);
      ptest(30, 0, 0, 0, 0, 1'b0);
      $display("test motors done");
      for (int i = 0; i < 3; i++) begin
         jf <= 3'(1 << i);
         cyc(3);
         lvl("jam", 1'b1, jam);
         lvl("motor_fail", 1'b0, motor_fail);
         clr;
      end
      $display("test jams done");
      print_verdict;
   end
endmodule // fmf_ctrl_tb_top
